// File: pccr_regs.sv
// Capability pointers, subsystem ids and express capability registers
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Pointer at 81h reads fixed 90h
// - Subsystem ids read-only, loaded by EEPROM/alias
// - Subsystem ids clear on any reset
// - Capability code at 90h reads 10h
// - Pointer at 91h reads 00h, list end
// - Port type field reads 7h, read-only
// - Version field reads 1h, read-only
// - Interrupt message number reads zero
// - Slot implemented bit reads zero
// - Top two capability bits read zero
// - Payload bits 9:8 captured as scale
// - Scale codes mean 1, .1, .01, .001
// - Payload bits 7:0 captured as value
// - Reserved device capability bits read zero
// - Device capabilities read-only, reset 00000D82h
module pccr_regs (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic perst_n,
  input wire logic global_reset_input_n,
  // Configuration access
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // Subsystem id loading
  input wire logic eeprom_load,
  input wire logic alias_wr,
  input wire logic [15:0] ss_vendor_in,
  input wire logic [15:0] ss_id_in,
  // Slot power message
  input wire logic spl_msg,
  input wire logic [31:0] spl_payload,
  // Captured power results
  output logic [1:0] captured_power_scale,
  output logic [7:0] captured_power_value,
  output logic [17:0] slot_power_limit_mw
);

  // ==========================================
  // Helpers
  function automatic logic [5:0] pccr_dword(input logic [7:0] a);
    pccr_dword = a[7:2];
  endfunction : pccr_dword

  function automatic logic [9:0] pccr_scale_mult(input logic [1:0] s);
    case (s)
      2'h0: pccr_scale_mult = pccr_pkg::PCCR_MULT_X1;
      2'h1: pccr_scale_mult = pccr_pkg::PCCR_MULT_X01;
      2'h2: pccr_scale_mult = pccr_pkg::PCCR_MULT_X001;
      default: pccr_scale_mult = pccr_pkg::PCCR_MULT_X0001;
    endcase
  endfunction : pccr_scale_mult

  // ==========================================
  // Register images, fixed fields plus captured power fields
  logic [15:0] exp_caps;
  logic [31:0] dev_caps;
  logic [31:0] rd_word;

  always_comb
  begin
    exp_caps = 16'h0000;
    exp_caps[pccr_pkg::PCCR_VERSION_POS +: 4] = pccr_pkg::PCCR_VERSION_VAL;
    exp_caps[pccr_pkg::PCCR_PORT_TYPE_POS +: 4] = pccr_pkg::PCCR_PORT_TYPE_VAL;
    exp_caps[pccr_pkg::PCCR_SLOT_POS +: 1] = pccr_pkg::PCCR_SLOT_VAL;
    exp_caps[pccr_pkg::PCCR_INT_NUM_POS +: 5] = pccr_pkg::PCCR_INT_NUM_VAL;
    dev_caps = 32'h00000000;
    dev_caps[14:0] = pccr_pkg::PCCR_DEV_CAPS_FIXED;
    dev_caps[pccr_pkg::PCCR_VALUE_POS +: 8] = captured_power_value;
    dev_caps[pccr_pkg::PCCR_SCALE_POS +: 2] = captured_power_scale;
  end

  // ==========================================
  // State
  logic [15:0] ss_vendor;
  logic [15:0] ss_id;
  logic [15:0] next_ss_vendor;
  logic [15:0] next_ss_id;
  logic [1:0] next_scale;
  logic [7:0] next_value;
  logic [17:0] next_limit;
  logic next_ack;
  logic [31:0] next_rdata;
  logic soft_rst;

  // Read mux by dword
  always_comb
  begin
    rd_word = 32'h00000000;
    if (pccr_dword(cfg_addr) == pccr_dword(pccr_pkg::PCCR_OFF_PTR_A))
    begin
      rd_word[8 * pccr_pkg::PCCR_OFF_PTR_A[1:0] +: 8] = pccr_pkg::PCCR_PTR_A_VAL;
    end
    else if (pccr_dword(cfg_addr) == pccr_dword(pccr_pkg::PCCR_OFF_SS_VENDOR))
    begin
      rd_word[8 * pccr_pkg::PCCR_OFF_SS_VENDOR[1:0] +: 16] = ss_vendor;
      rd_word[8 * pccr_pkg::PCCR_OFF_SS_ID[1:0] +: 16] = ss_id;
    end
    else if (pccr_dword(cfg_addr) == pccr_dword(pccr_pkg::PCCR_OFF_EXP_CODE))
    begin
      rd_word[8 * pccr_pkg::PCCR_OFF_EXP_CODE[1:0] +: 8] = pccr_pkg::PCCR_EXP_CODE_VAL;
      rd_word[8 * pccr_pkg::PCCR_OFF_PTR_B[1:0] +: 8] = pccr_pkg::PCCR_PTR_B_VAL;
      rd_word[8 * pccr_pkg::PCCR_OFF_EXP_CAPS[1:0] +: 16] = exp_caps;
    end
    else if (pccr_dword(cfg_addr) == pccr_dword(pccr_pkg::PCCR_OFF_DEV_CAPS))
    begin
      rd_word = dev_caps;
    end
  end

  // Link reset or global reset acts like power-on for these fields
  assign soft_rst = !perst_n || !global_reset_input_n;

  // Subsystem ids, changed only by reset, EEPROM load or alias write
  always_comb
  begin
    next_ss_vendor = ss_vendor;
    next_ss_id = ss_id;
    // Configuration writes deliberately touch nothing here
    if (soft_rst)
    begin
      next_ss_vendor = pccr_pkg::PCCR_SS_RESET;
      next_ss_id = pccr_pkg::PCCR_SS_RESET;
    end
    else if (eeprom_load || alias_wr)
    begin
      next_ss_vendor = ss_vendor_in;
      next_ss_id = ss_id_in;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ss_vendor <= pccr_pkg::PCCR_SS_RESET;
      ss_id <= pccr_pkg::PCCR_SS_RESET;
    end
    else
    begin
      ss_vendor <= next_ss_vendor;
      ss_id <= next_ss_id;
    end
  end

  // Captured slot power fields and the limit derived from them
  always_comb
  begin
    next_scale = captured_power_scale;
    next_value = captured_power_value;
    if (soft_rst)
    begin
      next_scale = pccr_pkg::PCCR_SCALE_RESET;
      next_value = pccr_pkg::PCCR_VALUE_RESET;
    end
    else if (spl_msg)
    begin
      next_scale = spl_payload[pccr_pkg::PCCR_PAY_SCALE_POS +: 2];
      next_value = spl_payload[pccr_pkg::PCCR_PAY_VALUE_POS +: 8];
    end
    // Widen before multiplying, the product needs all 18 bits
    next_limit = 18'(next_value) * 18'(pccr_scale_mult(next_scale));
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      captured_power_scale <= pccr_pkg::PCCR_SCALE_RESET;
      captured_power_value <= pccr_pkg::PCCR_VALUE_RESET;
      slot_power_limit_mw <= pccr_pkg::PCCR_LIMIT_RESET;
    end
    else
    begin
      captured_power_scale <= next_scale;
      captured_power_value <= next_value;
      slot_power_limit_mw <= next_limit;
    end
  end

  // Configuration answer, one cycle after the request
  always_comb
  begin
    next_ack = cfg_rd || cfg_wr;
    next_rdata = pccr_pkg::PCCR_RDATA_RESET;
    if (cfg_rd)
    begin
      next_rdata = rd_word;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_ack <= 1'b0;
      cfg_rdata <= pccr_pkg::PCCR_RDATA_RESET;
    end
    else
    begin
      cfg_ack <= next_ack;
      cfg_rdata <= next_rdata;
    end
  end

  // ==========================================
  // Checks
  chk_ptr_a_value: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_rd && cfg_addr[7:2] == 6'h20 |=> cfg_rdata[15:8] == 8'h90)
    else $error("pointer at 81h wrong");

  chk_ss_hold_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_wr && !eeprom_load && !alias_wr && !soft_rst |=> $stable(ss_vendor) && $stable(ss_id))
    else $error("subsystem id changed by config write");

  chk_ss_reset_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    !perst_n || !global_reset_input_n |=> ss_vendor == 16'h0000 && ss_id == 16'h0000)
    else $error("subsystem id not cleared");

  chk_exp_word: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_rd && cfg_addr[7:2] == 6'h24 |=> cfg_rdata == 32'h00710010)
    else $error("express capability dword wrong");

  chk_spl_capture: assert property (@(posedge sys_clk) disable iff (!nrst)
    spl_msg && !soft_rst |=> captured_power_scale == $past(spl_payload[9:8])
      && captured_power_value == $past(spl_payload[7:0]))
    else $error("slot power fields not captured");

  chk_limit_calc: assert property (@(posedge sys_clk) disable iff (!nrst)
    captured_power_scale == 2'h1 |-> slot_power_limit_mw == 18'(captured_power_value * 100))
    else $error("power limit scale wrong");

  chk_devcaps_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_rd && cfg_addr[7:2] == 6'h25 |=> cfg_rdata[31:28] == 4'h0
      && cfg_rdata[17:15] == 3'h0 && cfg_rdata[14:0] == 15'h0D82)
    else $error("device capabilities fixed bits wrong");

  chk_capture_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    !spl_msg && !soft_rst |=> $stable(captured_power_scale) && $stable(captured_power_value))
    else $error("captured power changed without message");

  chk_ack_timing: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_rd |=> cfg_ack ##1 (cfg_ack == $past(cfg_rd || cfg_wr)))
    else $error("configuration answer late");

  chk_ptr_b_end: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_rd && cfg_addr[7:2] == 6'h24 |=> cfg_rdata[15:8] == 8'h00)
    else $error("pointer at 91h not list end");

  chk_port_type: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_rd && cfg_addr[7:2] == 6'h24 |=> cfg_rdata[23:20] == 4'h7)
    else $error("device port type wrong");

  chk_cap_version: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_rd && cfg_addr[7:2] == 6'h24 |=> cfg_rdata[19:16] == 4'h1)
    else $error("capability version wrong");

  chk_int_number: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_rd && cfg_addr[7:2] == 6'h24 |=> cfg_rdata[29:25] == 5'h00)
    else $error("interrupt message number not zero");

  chk_slot_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_rd && cfg_addr[7:2] == 6'h24 |=> cfg_rdata[24] == 1'b0)
    else $error("slot implemented bit set");

  chk_caps_reserved: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_rd && cfg_addr[7:2] == 6'h24 |=> cfg_rdata[31:30] == 2'h0)
    else $error("reserved capability bits set");

  chk_ss_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_rd && cfg_addr[7:2] == 6'h21 |=> cfg_rdata == {$past(ss_id), $past(ss_vendor)})
    else $error("subsystem id read wrong");

  chk_devcaps_fields: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_rd && cfg_addr[7:2] == 6'h25 |=> cfg_rdata[27:26] == $past(captured_power_scale)
      && cfg_rdata[25:18] == $past(captured_power_value))
    else $error("captured power fields read wrong");

  chk_scale_unit: assert property (@(posedge sys_clk) disable iff (!nrst)
    captured_power_scale == 2'h0 |-> slot_power_limit_mw == 18'(captured_power_value * 1000))
    else $error("power limit unit scale wrong");

  chk_scale_hundredth: assert property (@(posedge sys_clk) disable iff (!nrst)
    captured_power_scale == 2'h2 |-> slot_power_limit_mw == 18'(captured_power_value * 10))
    else $error("power limit hundredth scale wrong");

  chk_scale_thousandth: assert property (@(posedge sys_clk) disable iff (!nrst)
    captured_power_scale == 2'h3 |-> slot_power_limit_mw == 18'(captured_power_value))
    else $error("power limit thousandth scale wrong");

  chk_soft_clear_power: assert property (@(posedge sys_clk) disable iff (!nrst)
    soft_rst |=> captured_power_scale == 2'h0 && captured_power_value == 8'h00
      && slot_power_limit_mw == 18'h00000)
    else $error("captured power not cleared");

  chk_write_no_data: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_wr && !cfg_rd && cfg_wdata != 32'h00000000 |=> cfg_ack && cfg_rdata == 32'h00000000)
    else $error("write returned data");

  chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
    !cfg_rd && !cfg_wr |=> !cfg_ack && cfg_rdata == 32'h00000000)
    else $error("answer without request");

endmodule : pccr_regs

`default_nettype wire

// File: pccr_pkg.sv
// Constants for the capability and identification register bank
package pccr_pkg;

  // ==========================================
  // Register byte offsets
  localparam logic [7:0] PCCR_OFF_PTR_A = 8'h81;
  localparam logic [7:0] PCCR_OFF_SS_VENDOR = 8'h84;
  localparam logic [7:0] PCCR_OFF_SS_ID = 8'h86;
  localparam logic [7:0] PCCR_OFF_EXP_CODE = 8'h90;
  localparam logic [7:0] PCCR_OFF_PTR_B = 8'h91;
  localparam logic [7:0] PCCR_OFF_EXP_CAPS = 8'h92;
  localparam logic [7:0] PCCR_OFF_DEV_CAPS = 8'h94;

  // ==========================================
  // Fixed and reset values
  localparam logic [7:0] PCCR_PTR_A_VAL = 8'h90;
  localparam logic [7:0] PCCR_EXP_CODE_VAL = 8'h10;
  localparam logic [7:0] PCCR_PTR_B_VAL = 8'h00;
  localparam logic [15:0] PCCR_SS_RESET = 16'h0000;
  localparam logic [31:0] PCCR_DEV_CAPS_RESET = 32'h00000D82;
  localparam logic [17:0] PCCR_LIMIT_RESET = 18'h00000;
  localparam logic [31:0] PCCR_RDATA_RESET = 32'h00000000;

  // ==========================================
  // Express capabilities fields
  localparam int PCCR_VERSION_POS = 0;
  localparam logic [3:0] PCCR_VERSION_VAL = 4'h1;
  localparam int PCCR_PORT_TYPE_POS = 4;
  localparam logic [3:0] PCCR_PORT_TYPE_VAL = 4'h7;
  localparam int PCCR_SLOT_POS = 8;
  localparam logic [0:0] PCCR_SLOT_VAL = 1'h0;
  localparam int PCCR_INT_NUM_POS = 9;
  localparam logic [4:0] PCCR_INT_NUM_VAL = 5'h00;
  localparam logic [15:0] PCCR_EXP_CAPS_RESET = 16'h0071;

  // ==========================================
  // Device capabilities fields
  localparam logic [14:0] PCCR_DEV_CAPS_FIXED = 15'h0D82;
  localparam int PCCR_VALUE_POS = 18;
  localparam int PCCR_SCALE_POS = 26;
  localparam int PCCR_PAY_VALUE_POS = 0;
  localparam int PCCR_PAY_SCALE_POS = 8;
  localparam logic [1:0] PCCR_SCALE_RESET = 2'h0;
  localparam logic [7:0] PCCR_VALUE_RESET = 8'h00;

  // ==========================================
  // Scale multipliers expressed in milli units
  localparam logic [9:0] PCCR_MULT_X1 = 10'h3E8;
  localparam logic [9:0] PCCR_MULT_X01 = 10'h064;
  localparam logic [9:0] PCCR_MULT_X001 = 10'h00A;
  localparam logic [9:0] PCCR_MULT_X0001 = 10'h001;

endpackage : pccr_pkg

// File: pccr_host_model.sv
// Upstream host model issuing configuration accesses and power messages
`timescale 1ns/10ps
`default_nettype none
module pccr_host_model (
  // Clock
  input wire logic sys_clk,
  // Configuration access
  output logic cfg_rd,
  output logic cfg_wr,
  output logic [7:0] cfg_addr,
  output logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  // Slot power message
  output logic spl_msg,
  output logic [31:0] spl_payload
);
  // ==========================================
  // Idle state
  initial
  begin
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h00000000;
    spl_msg = 1'b0;
    spl_payload = 32'h00000000;
  end

  // ==========================================
  // One access, answer taken one cycle later
  task automatic access(input logic rd, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic ack, output logic [31:0] data);
    @(negedge sys_clk);
    cfg_rd = rd;
    cfg_wr = !rd;
    cfg_addr = addr;
    cfg_wdata = wdata;
    @(negedge sys_clk);
    ack = cfg_ack;
    data = cfg_rdata;
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    // Released address and data lines show inverted last value
    cfg_addr = ~addr;
    cfg_wdata = ~wdata;
  endtask : access

  // ==========================================
  // Power limit message, scale in 9:8, value in 7:0
  task automatic message(input logic [31:0] payload);
    @(negedge sys_clk);
    spl_msg = 1'b1;
    spl_payload = payload;
    @(negedge sys_clk);
    spl_msg = 1'b0;
    spl_payload = ~payload;
  endtask : message
endmodule : pccr_host_model
`default_nettype wire

// File: pcie_capability_config_regs_bench.sv
// Self-checking bench for the capability register bank
`timescale 1ns/10ps
`default_nettype none
module pcie_capability_config_regs_bench;
  logic sys_clk, nrst, perst_n, global_reset_input_n, cfg_rd, cfg_wr, cfg_ack, ack;
  logic eeprom_load, alias_wr;
  wire logic spl_msg_w;
  logic [7:0] cfg_addr, value, val_q;
  logic [31:0] cfg_wdata, cfg_rdata, spl_payload, got;
  logic [15:0] ss_vendor_in, ss_id_in;
  logic [1:0] scale;
  logic [17:0] limit;
  logic [17:0] mult [4] = '{18'h003E8, 18'h00064, 18'h0000A, 18'h00001};
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;

  pccr_regs dut_u (.sys_clk(sys_clk), .nrst(nrst), .perst_n(perst_n),
    .global_reset_input_n(global_reset_input_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .eeprom_load(eeprom_load), .alias_wr(alias_wr), .ss_vendor_in(ss_vendor_in),
    .ss_id_in(ss_id_in), .spl_msg(spl_msg_w), .spl_payload(spl_payload),
    .captured_power_scale(scale), .captured_power_value(value), .slot_power_limit_mw(limit));
  pccr_host_model host_u (.sys_clk(sys_clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .spl_msg(spl_msg_w), .spl_payload(spl_payload));

  // ==========================================
  // Clock and watchdog
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    host_u.access(1'b1, a, 32'h00000000, ack, got);
    chk({31'h0, ack}, 32'h00000001);
    chk(got, e);
  endtask : rd_chk
  task automatic wr(input logic [7:0] a);
    host_u.access(1'b0, a, 32'hFFFFFFFF, ack, got);
    chk({31'h0, ack}, 32'h00000001);
    chk(got, 32'h00000000);
  endtask : wr
  task automatic load(input logic sel, input logic [15:0] v, input logic [15:0] i);
    @(negedge sys_clk);
    ss_vendor_in = v;
    ss_id_in = i;
    eeprom_load = !sel;
    alias_wr = sel;
    @(negedge sys_clk);
    eeprom_load = 1'b0;
    alias_wr = 1'b0;
    ss_vendor_in = ~v;
    ss_id_in = ~i;
  endtask : load
  task automatic wrap_up;
    $display("Mismatches %0d, compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // ==========================================
  // Test sequence
  initial
  begin
    {nrst, eeprom_load, alias_wr, ss_vendor_in, ss_id_in} = '0;
    {perst_n, global_reset_input_n} = 2'b11;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    rd_chk(8'h81, 32'h00009000);
    rd_chk(8'h84, 32'h00000000);
    rd_chk(8'h90, 32'h00710010);
    rd_chk(8'h94, 32'h00000D82);
    rd_chk(8'h88, 32'h00000000);
    load(1'b0, 16'h1A2B, 16'h3C4D);
    rd_chk(8'h86, 32'h3C4D1A2B);
    load(1'b1, 16'h5E6F, 16'h7081);
    rd_chk(8'h84, 32'h70815E6F);
    for (int i = 0; i < 4; i++)
    begin
      val_q = 8'hFF >> (2 * i);
      host_u.message({22'h3FFFFF, 2'(i), val_q});
      chk({22'h0, scale, value}, {22'h0, 2'(i), val_q});
      chk({14'h0, limit}, {14'h0, 18'(val_q) * mult[i]});
      rd_chk(8'h94, {4'h0, 2'(i), val_q, 3'h0, 15'h0D82});
    end
    wr(8'h94);
    wr(8'h84);
    wr(8'h90);
    rd_chk(8'h94, 32'h0C0C0D82);
    rd_chk(8'h84, 32'h70815E6F);
    rd_chk(8'h90, 32'h00710010);
    for (int r = 0; r < 3; r++)
    begin
      load(1'b0, 16'hBEEF, 16'h0123);
      host_u.message(32'hFFFFFF3C);
      rd_chk(8'h84, 32'h0123BEEF);
      rd_chk(8'h94, 32'h0CF00D82);
      @(negedge sys_clk);
      perst_n = (r != 0);
      global_reset_input_n = (r != 1);
      nrst = (r != 2);
      @(negedge sys_clk);
      {perst_n, global_reset_input_n, nrst} = 3'b111;
      rd_chk(8'h84, 32'h00000000);
      rd_chk(8'h94, 32'h00000D82);
      chk({14'h0, limit}, 32'h00000000);
    end
    wrap_up();
  end
endmodule : pcie_capability_config_regs_bench
`default_nettype wire
